// file: design/dxr_ctrl_regs.sv
// serial-loaded write-only control register bank with applied outputs
`timescale 1ns/10ps
module dxr_ctrl_regs (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    input  wire logic       extended_mode_i,
    input  wire logic       serial_clock_i,
    input  wire logic       serial_select_n_i,
    input  wire logic       serial_data_in_i,
    input  wire logic       output_edge_pin_i,
    input  wire logic       output_swing_pin_i,
    output logic            clock_duty_stabilizer_en_o,
    output logic            double_rate_clock_phase_o,
    output logic            single_rate_select_o,
    output logic            output_swing_select_o,
    output logic            output_edge_select_o,
    output logic [7:0]      first_offset_mag_o,
    output logic            first_offset_neg_o,
    output logic [8:0]      first_gain_code_o,
    output logic [7:0]      second_offset_mag_o,
    output logic            second_offset_neg_o,
    output logic [8:0]      second_gain_code_o,
    output logic            interleave_en_o,
    output logic            auto_phase_en_o,
    output logic            interleave_input_select_o,
    output logic            skew_target_select_o,
    output logic [2:0]      coarse_skew_magnitude_o,
    output logic            write_strobe_o
);
    // ==========================================================
    // usage notes
    //
    // timing of one write, counted in system clocks:
    // - serial pins are asynchronous and pass two flops first
    // - a serial clock rise is seen about three clocks after the pin edge
    // - the 32nd rise with a good header writes the stored word
    // - write_strobe_o rises on that same edge, for one cycle
    // - applied outputs follow one clock after the stored word
    //
    // serial clock limits:
    // - each serial clock level must last at least three system clocks
    // - a shorter level may be missed by the edge finder
    // - select must be low one clock before the first rise is seen
    //
    // frame handling:
    // - bits are counted from select going low in extended mode
    // - a frame cut short by deselect is dropped whole
    // - leaving extended mode mid-frame drops the frame as well
    // - chained frames need no deselect; the count wraps at 32
    // - a bad header drops the frame but keeps the count aligned
    // - reserved addresses are counted as frames and then ignored
    //
    // stored versus applied values:
    // - the stored words keep their contents across normal mode
    // - normal mode shows power-on values on every applied output but edge and swing
    // - edge and swing follow their pins in normal mode instead
    // - returning to extended mode reapplies the stored words
    //
    // automatic phase:
    // - while automatic phase is on, the coarse delay output is zero
    // - the stored coarse code is kept and returns when it is cleared
    //
    // hazards left to the host:
    // - no read-back: the host keeps its own copy of every word
    // - fixed bits are stored as written and not checked
    // - writing the configuration word with interleave on is not blocked
    // - gain codes outside the advised range are applied as written
    //
    // clock enable:
    // - enable_i low freezes synchronisers, receiver and outputs alike
    // - serial clock pulses that begin and end while frozen are lost
    //
    // reset:
    // - rst_i is asynchronous; every flop takes a constant value
    // - outputs show power-on fields while reset is held
    // - start the first frame a few clocks after release
    //
    // trade-offs:
    // - sampling the serial clock keeps the whole block on one clock
    // - the price is a serial clock far slower than the system clock
    // - applied values are registered so every output is a flop
    //
    // ==========================================================
    // input synchronisers
    logic [2:0] sclk_sync;
    logic [1:0] sel_sync;
    logic [1:0] dat_sync;
    logic [1:0] mode_sync;
    logic [1:0] edge_sync;
    logic [1:0] swing_sync;

    // two flops per outside input, third stage on the clock for edge finding
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_sync  <= 3'h0;
            sel_sync   <= 2'h3;
            dat_sync   <= 2'h0;
            mode_sync  <= 2'h0;
            edge_sync  <= 2'h0;
            swing_sync <= 2'h3;
        end else if (enable_i) begin
            sclk_sync  <= {sclk_sync[1:0], serial_clock_i};
            sel_sync   <= {sel_sync[0], serial_select_n_i};
            dat_sync   <= {dat_sync[0], serial_data_in_i};
            mode_sync  <= {mode_sync[0], extended_mode_i};
            edge_sync  <= {edge_sync[0], output_edge_pin_i};
            swing_sync <= {swing_sync[0], output_swing_pin_i};
        end
    end

    logic sclk_rise;
    logic selected;
    logic ext_mode;
    assign sclk_rise = sclk_sync[1] & ~sclk_sync[2]; // rising serial clock edge
    assign selected  = ~sel_sync[1];
    assign ext_mode  = mode_sync[1];

    // ==========================================================
    // frame receiver
    dxr_pkg::dxr_state_t state;
    logic [31:0]         shift;
    logic [5:0]          bit_count;
    logic [31:0]         next_shift;
    logic                frame_done;

    assign next_shift = {shift[30:0], dat_sync[1]}; // msb first
    assign frame_done = (state == dxr_pkg::DXR_SHIFT) && sclk_rise && selected
                        && (bit_count == dxr_pkg::FRAME_BITS - 6'h1);

    // shift bits while selected in extended mode; deselect aborts a frame
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state     <= dxr_pkg::DXR_IDLE;
            shift     <= 32'h0;
            bit_count <= 6'h0;
        end else if (enable_i) begin
            case (state)
                dxr_pkg::DXR_IDLE: begin
                    bit_count <= 6'h0;
                    if (selected && ext_mode) begin
                        state <= dxr_pkg::DXR_SHIFT;
                    end
                end
                dxr_pkg::DXR_SHIFT: begin
                    if (!selected || !ext_mode) begin
                        state     <= dxr_pkg::DXR_IDLE;
                        bit_count <= 6'h0;
                    end else if (sclk_rise) begin
                        shift <= next_shift;
                        if (frame_done) begin
                            bit_count <= 6'h0; // next frame starts at 33rd clock
                        end else begin
                            bit_count <= bit_count + 6'h1;
                        end
                    end
                end
                default: begin
                    state <= dxr_pkg::DXR_IDLE;
                end
            endcase
        end
    end

    logic        frame_ok;
    logic [3:0]  frame_addr;
    logic [15:0] frame_data;
    assign frame_ok   = frame_done && (next_shift[dxr_pkg::HDR_HI:dxr_pkg::HDR_LO]
                        == dxr_pkg::FRAME_HEADER);
    assign frame_addr = next_shift[dxr_pkg::ADR_HI:dxr_pkg::ADR_LO];
    assign frame_data = next_shift[dxr_pkg::DAT_HI:dxr_pkg::DAT_LO];

    // ==========================================================
    // register bank, write only with no read path
    logic [15:0] cfg_reg;
    logic [15:0] ofs1_reg;
    logic [15:0] gain1_reg;
    logic [15:0] ofs2_reg;
    logic [15:0] gain2_reg;
    logic [15:0] ilv_reg;
    logic [15:0] skew_reg;

    // full frame updates the addressed word; reserved addresses fall through
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg   <= dxr_pkg::RST_CONFIG;
            ofs1_reg  <= dxr_pkg::RST_OFS;
            gain1_reg <= dxr_pkg::RST_GAIN;
            ofs2_reg  <= dxr_pkg::RST_OFS;
            gain2_reg <= dxr_pkg::RST_GAIN;
            ilv_reg   <= dxr_pkg::RST_INTERLEAVE;
            skew_reg  <= dxr_pkg::RST_SKEW;
        end else if (enable_i && frame_ok) begin
            if (frame_addr == dxr_pkg::ADDR_CONFIG) begin
                cfg_reg <= frame_data;
            end else if (frame_addr == dxr_pkg::ADDR_OFS_FIRST) begin
                ofs1_reg <= frame_data;
            end else if (frame_addr == dxr_pkg::ADDR_GAIN_FIRST) begin
                gain1_reg <= frame_data;
            end else if (frame_addr == dxr_pkg::ADDR_OFS_SECOND) begin
                ofs2_reg <= frame_data;
            end else if (frame_addr == dxr_pkg::ADDR_GAIN_SECOND) begin
                gain2_reg <= frame_data;
            end else if (frame_addr == dxr_pkg::ADDR_INTERLEAVE) begin
                ilv_reg <= frame_data;
            end else if (frame_addr == dxr_pkg::ADDR_COARSE_SKEW) begin
                skew_reg <= frame_data;
            end
        end
    end

    // one-cycle pulse marking an accepted write to a mapped register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            write_strobe_o <= 1'b0;
        end else if (enable_i) begin
            write_strobe_o <= frame_ok && (frame_addr == dxr_pkg::ADDR_CONFIG
                || frame_addr == dxr_pkg::ADDR_OFS_FIRST
                || frame_addr == dxr_pkg::ADDR_GAIN_FIRST
                || frame_addr == dxr_pkg::ADDR_OFS_SECOND
                || frame_addr == dxr_pkg::ADDR_GAIN_SECOND
                || frame_addr == dxr_pkg::ADDR_INTERLEAVE
                || frame_addr == dxr_pkg::ADDR_COARSE_SKEW);
        end
    end

    // ==========================================================
    // applied settings: register fields in extended mode, power-on defaults or the edge and swing pins otherwise
    logic [15:0] cfg_eff;
    logic [15:0] ofs1_eff;
    logic [15:0] gain1_eff;
    logic [15:0] ofs2_eff;
    logic [15:0] gain2_eff;
    logic [15:0] ilv_eff;
    logic [15:0] skew_eff;

    // normal mode ignores the stored contents
    always_comb begin
        cfg_eff   = ext_mode ? cfg_reg   : dxr_pkg::RST_CONFIG;
        ofs1_eff  = ext_mode ? ofs1_reg  : dxr_pkg::RST_OFS;
        gain1_eff = ext_mode ? gain1_reg : dxr_pkg::RST_GAIN;
        ofs2_eff  = ext_mode ? ofs2_reg  : dxr_pkg::RST_OFS;
        gain2_eff = ext_mode ? gain2_reg : dxr_pkg::RST_GAIN;
        ilv_eff   = ext_mode ? ilv_reg   : dxr_pkg::RST_INTERLEAVE;
        skew_eff  = ext_mode ? skew_reg  : dxr_pkg::RST_SKEW;
    end

    // output clocking fields; in normal mode edge and swing follow their pins
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            clock_duty_stabilizer_en_o <= dxr_pkg::RST_CONFIG[dxr_pkg::CFG_DUTY];
            double_rate_clock_phase_o  <= dxr_pkg::RST_CONFIG[dxr_pkg::CFG_PHASE];
            single_rate_select_o       <= dxr_pkg::RST_CONFIG[dxr_pkg::CFG_SDR];
            output_swing_select_o      <= dxr_pkg::RST_CONFIG[dxr_pkg::CFG_SWING];
            output_edge_select_o       <= dxr_pkg::RST_CONFIG[dxr_pkg::CFG_EDGE];
        end else if (enable_i) begin
            clock_duty_stabilizer_en_o <= cfg_eff[dxr_pkg::CFG_DUTY];
            double_rate_clock_phase_o  <= cfg_eff[dxr_pkg::CFG_PHASE];
            single_rate_select_o       <= cfg_eff[dxr_pkg::CFG_SDR];
            output_swing_select_o      <= ext_mode ? cfg_reg[dxr_pkg::CFG_SWING]
                                                   : swing_sync[1];
            output_edge_select_o       <= ext_mode ? cfg_reg[dxr_pkg::CFG_EDGE]
                                                   : edge_sync[1];
        end
    end

    // offset and gain fields, applied directly with no calibration step
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            first_offset_mag_o  <= dxr_pkg::RST_OFS[dxr_pkg::OFS_MAG_HI:dxr_pkg::OFS_MAG_LO];
            first_offset_neg_o  <= dxr_pkg::RST_OFS[dxr_pkg::OFS_SIGN];
            first_gain_code_o   <= dxr_pkg::RST_GAIN[dxr_pkg::GAIN_HI:dxr_pkg::GAIN_LO];
            second_offset_mag_o <= dxr_pkg::RST_OFS[dxr_pkg::OFS_MAG_HI:dxr_pkg::OFS_MAG_LO];
            second_offset_neg_o <= dxr_pkg::RST_OFS[dxr_pkg::OFS_SIGN];
            second_gain_code_o  <= dxr_pkg::RST_GAIN[dxr_pkg::GAIN_HI:dxr_pkg::GAIN_LO];
        end else if (enable_i) begin
            first_offset_mag_o  <= ofs1_eff[dxr_pkg::OFS_MAG_HI:dxr_pkg::OFS_MAG_LO];
            first_offset_neg_o  <= ofs1_eff[dxr_pkg::OFS_SIGN];
            first_gain_code_o   <= gain1_eff[dxr_pkg::GAIN_HI:dxr_pkg::GAIN_LO];
            second_offset_mag_o <= ofs2_eff[dxr_pkg::OFS_MAG_HI:dxr_pkg::OFS_MAG_LO];
            second_offset_neg_o <= ofs2_eff[dxr_pkg::OFS_SIGN];
            second_gain_code_o  <= gain2_eff[dxr_pkg::GAIN_HI:dxr_pkg::GAIN_LO];
        end
    end

    // interleave and skew; automatic phase forces the manual skew to zero
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            interleave_en_o           <= dxr_pkg::RST_INTERLEAVE[dxr_pkg::ILV_EN];
            auto_phase_en_o           <= dxr_pkg::RST_INTERLEAVE[dxr_pkg::ILV_AUTO];
            interleave_input_select_o <= dxr_pkg::RST_SKEW[dxr_pkg::SKW_INPUT];
            skew_target_select_o      <= dxr_pkg::RST_SKEW[dxr_pkg::SKW_TARGET];
            coarse_skew_magnitude_o   <= dxr_pkg::RST_SKEW[dxr_pkg::SKW_MAG_HI:dxr_pkg::SKW_MAG_LO];
        end else if (enable_i) begin
            interleave_en_o           <= ilv_eff[dxr_pkg::ILV_EN];
            auto_phase_en_o           <= ilv_eff[dxr_pkg::ILV_AUTO];
            interleave_input_select_o <= skew_eff[dxr_pkg::SKW_INPUT];
            skew_target_select_o      <= skew_eff[dxr_pkg::SKW_TARGET];
            if (ilv_eff[dxr_pkg::ILV_AUTO]) begin
                coarse_skew_magnitude_o <= 3'h0;
            end else begin
                coarse_skew_magnitude_o <= skew_eff[dxr_pkg::SKW_MAG_HI:dxr_pkg::SKW_MAG_LO];
            end
        end
    end
endmodule

// file: design/dxr_pkg.sv
// constants for the dual converter extended control register bank
package dxr_pkg;
    // register addresses carried in the 4-bit frame address field
    localparam logic [3:0] ADDR_CONFIG      = 4'h1;
    localparam logic [3:0] ADDR_OFS_FIRST   = 4'h2;
    localparam logic [3:0] ADDR_GAIN_FIRST  = 4'h3;
    localparam logic [3:0] ADDR_OFS_SECOND  = 4'ha;
    localparam logic [3:0] ADDR_GAIN_SECOND = 4'hb;
    localparam logic [3:0] ADDR_INTERLEAVE  = 4'hd;
    localparam logic [3:0] ADDR_COARSE_SKEW = 4'he;
    // power-on values
    localparam logic [15:0] RST_CONFIG     = 16'hb2ff;
    localparam logic [15:0] RST_OFS        = 16'h007f;
    localparam logic [15:0] RST_GAIN       = 16'h807f;
    localparam logic [15:0] RST_INTERLEAVE = 16'h3fff;
    localparam logic [15:0] RST_SKEW       = 16'h07ff;
    // frame layout
    localparam logic [11:0] FRAME_HEADER = 12'h001;
    localparam logic [5:0]  FRAME_BITS   = 6'h20;
    localparam int HDR_HI  = 31;
    localparam int HDR_LO  = 20;
    localparam int ADR_HI  = 19;
    localparam int ADR_LO  = 16;
    localparam int DAT_HI  = 15;
    localparam int DAT_LO  = 0;
    // field positions
    localparam int CFG_DUTY   = 12;
    localparam int CFG_PHASE  = 11;
    localparam int CFG_SDR    = 10;
    localparam int CFG_SWING  = 9;
    localparam int CFG_EDGE   = 8;
    localparam int OFS_MAG_HI = 15;
    localparam int OFS_MAG_LO = 8;
    localparam int OFS_SIGN   = 7;
    localparam int GAIN_HI    = 15;
    localparam int GAIN_LO    = 7;
    localparam int ILV_EN     = 15;
    localparam int ILV_AUTO   = 14;
    localparam int SKW_INPUT  = 15;
    localparam int SKW_TARGET = 14;
    localparam int SKW_MAG_HI = 13;
    localparam int SKW_MAG_LO = 11;
    // frame receiver states
    typedef enum logic [1:0] {
        DXR_IDLE  = 2'b01,
        DXR_SHIFT = 2'b10
    } dxr_state_t;
endpackage

// file: testbench/dxr_ctrl_regs_assertions.sv
// port checker for the serial control register bank
`timescale 1ns/10ps
module dxr_ctrl_regs_assertions (
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic       enable_i,
    input wire logic       extended_mode_i,
    input wire logic       serial_clock_i,
    input wire logic       output_edge_pin_i,
    input wire logic       output_swing_pin_i,
    input wire logic       clock_duty_stabilizer_en_o,
    input wire logic       double_rate_clock_phase_o,
    input wire logic       single_rate_select_o,
    input wire logic       output_swing_select_o,
    input wire logic       output_edge_select_o,
    input wire logic [7:0] first_offset_mag_o,
    input wire logic       first_offset_neg_o,
    input wire logic [8:0] first_gain_code_o,
    input wire logic [7:0] second_offset_mag_o,
    input wire logic       second_offset_neg_o,
    input wire logic [8:0] second_gain_code_o,
    input wire logic       interleave_en_o,
    input wire logic       auto_phase_en_o,
    input wire logic       interleave_input_select_o,
    input wire logic       skew_target_select_o,
    input wire logic [2:0] coarse_skew_magnitude_o,
    input wire logic       write_strobe_o
);
    // ==========================================
    // properties
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    logic        norm;
    logic [47:0] fields;
    // normal mode with clock running, and all applied field outputs in one vector
    assign norm = !extended_mode_i && enable_i;
    assign fields = {clock_duty_stabilizer_en_o, double_rate_clock_phase_o,
        single_rate_select_o, output_swing_select_o, output_edge_select_o,
        first_offset_mag_o, first_offset_neg_o, first_gain_code_o,
        second_offset_mag_o, second_offset_neg_o, second_gain_code_o,
        interleave_en_o, auto_phase_en_o, interleave_input_select_o,
        skew_target_select_o, coarse_skew_magnitude_o};
    a_normal_clocking: assert property (norm [*5] |-> clock_duty_stabilizer_en_o
        && !double_rate_clock_phase_o && !single_rate_select_o)
        else $error("clocking fields not at defaults in normal mode");
    a_normal_analog: assert property (norm [*5] |-> first_gain_code_o == 9'h100
        && second_gain_code_o == 9'h100 && first_offset_mag_o == 8'h00 && !interleave_en_o)
        else $error("analog fields not at defaults in normal mode");
    a_swing_pin: assert property ((norm && $stable(output_swing_pin_i)) [*6]
        |-> output_swing_select_o == output_swing_pin_i) else $error("swing not from pin");
    a_edge_pin: assert property ((norm && $stable(output_edge_pin_i)) [*6]
        |-> output_edge_select_o == output_edge_pin_i) else $error("edge not from pin");
    a_auto_skew: assert property (auto_phase_en_o |-> coarse_skew_magnitude_o == 3'h0)
        else $error("manual skew active under auto phase");
    a_strobe_single: assert property (write_strobe_o |=> !write_strobe_o)
        else $error("write strobe longer than one cycle");
    a_strobe_mode: assert property (write_strobe_o |-> $past(extended_mode_i, 4))
        else $error("write taken outside extended mode");
    a_strobe_sclk: assert property (write_strobe_o |-> serial_clock_i
        && $past(serial_clock_i, 3)) else $error("write not after a serial clock rise");
    a_hold_fields: assert property ((extended_mode_i && enable_i) [*6] ##0
        $changed(fields) |-> $past(write_strobe_o)) else $error("field changed without a write");
    c_write: cover property (write_strobe_o);
    c_auto: cover property (auto_phase_en_o && interleave_en_o);
    c_mode_back: cover property (norm [*5] ##1 extended_mode_i);
endmodule

// file: testbench/dxr_host_model.sv
// host model that shifts write frames into the three-wire port
`timescale 1ns/10ps
module dxr_host_model (
    input  wire logic clock_i,
    output logic      serial_clock_o,
    output logic      serial_select_n_o,
    output logic      serial_data_o
);
    // ==========================================
    // idle levels: deselected, serial clock resting low
    initial begin
        serial_clock_o = 1'b0;
        serial_select_n_o = 1'b1;
        serial_data_o = 1'b0;
    end
    // shift n bits msb first, data steady around each rising edge
    task automatic send(input logic [31:0] w, input int n, input logic keep);
        if (serial_select_n_o) begin
            serial_select_n_o <= 1'b0;
            repeat (4) @(posedge clock_i);
        end
        for (int i = 31; i > 31 - n; i--) begin
            serial_data_o <= w[i];
            repeat (16) @(posedge clock_i);
            serial_clock_o <= 1'b1;
            repeat (16) @(posedge clock_i);
            serial_clock_o <= 1'b0;
        end
        // keep select low to chain frames; released data shows the inverse
        if (!keep) begin
            serial_select_n_o <= 1'b1;
            serial_data_o <= ~w[32 - n];
            repeat (4) @(posedge clock_i);
        end
    endtask
endmodule

// file: testbench/dxr_ctrl_regs_bench.sv
// self-checking bench for the serial control register bank
`timescale 1ns/10ps
module dxr_ctrl_regs_bench;
    logic clock_i, rst_i, enable_i, extended_mode_i, serial_clock_i, serial_select_n_i;
    logic serial_data_in_i, output_edge_pin_i, output_swing_pin_i, write_strobe_o;
    logic clock_duty_stabilizer_en_o, double_rate_clock_phase_o, single_rate_select_o;
    logic output_swing_select_o, output_edge_select_o, first_offset_neg_o;
    logic second_offset_neg_o, interleave_en_o, auto_phase_en_o;
    logic interleave_input_select_o, skew_target_select_o;
    logic [7:0]  first_offset_mag_o, second_offset_mag_o;
    logic [8:0]  first_gain_code_o, second_gain_code_o;
    logic [2:0]  coarse_skew_magnitude_o;
    logic [15:0] rv [16];
    logic [15:0] sh [16];
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    dxr_ctrl_regs dut (.*);
    dxr_host_model host (
        .clock_i           (clock_i),
        .serial_clock_o    (serial_clock_i),
        .serial_select_n_o (serial_select_n_i),
        .serial_data_o     (serial_data_in_i)
    );
    // ==========================================
    // clock and hang guard
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end
    // compare one field
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // compare every field output against the shadow, or defaults and the edge and swing pins in normal mode
    task automatic check_regs(input logic n);
        logic [15:0] e [16];
        foreach (e[a]) e[a] = n ? rv[a] : sh[a];
        chk(clock_duty_stabilizer_en_o, e[1][12]);
        chk(double_rate_clock_phase_o, e[1][11]);
        chk(single_rate_select_o, e[1][10]);
        chk(output_swing_select_o, n ? output_swing_pin_i : e[1][9]);
        chk(output_edge_select_o, n ? output_edge_pin_i : e[1][8]);
        chk(first_offset_mag_o, e[2][15:8]);
        chk(first_offset_neg_o, e[2][7]);
        chk(first_gain_code_o, e[3][15:7]);
        chk(second_offset_mag_o, e[10][15:8]);
        chk(second_offset_neg_o, e[10][7]);
        chk(second_gain_code_o, e[11][15:7]);
        chk(interleave_en_o, e[13][15]);
        chk(auto_phase_en_o, e[13][14]);
        chk(interleave_input_select_o, e[14][15]);
        chk(skew_target_select_o, e[14][14]);
        chk(coarse_skew_magnitude_o, e[13][14] ? 3'h0 : e[14][13:11]);
    endtask
    // one accepted write frame, shadow follows
    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic keep);
        host.send({dxr_pkg::FRAME_HEADER, a, d}, 32, keep);
        sh[a] = d;
    endtask
    task automatic t_first_pass();
        logic [3:0] al [8] = '{4'hd, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'he, 4'hf};
        foreach (al[i]) wr(al[i], rv[al[i]], i < 7);
        check_regs(1'b0);
    endtask
    task automatic t_config();
        for (int i = 0; i < 6; i++) begin
            wr(4'h1, {3'b101, 5'h1f ^ (5'h01 << i), 8'hff}, 1'b0);
            check_regs(1'b0);
        end
    endtask
    task automatic t_channels();
        wr(4'h2, {8'hff, 1'b1, 7'h7f}, 1'b1);
        wr(4'h3, {9'h0c0, 7'h7f}, 1'b1);
        wr(4'ha, {8'h01, 1'b0, 7'h7f}, 1'b1);
        wr(4'hb, {9'h1c0, 7'h7f}, 1'b0);
        check_regs(1'b0);
        wr(4'h3, {9'h1c0, 7'h7f}, 1'b0);
        check_regs(1'b0);
    endtask
    task automatic t_interleave();
        logic [15:0] il [3] = '{16'hbfff, 16'hffff, 16'h3fff};
        wr(4'he, {2'b11, 3'h7, 11'h7ff}, 1'b0);
        check_regs(1'b0);
        foreach (il[i]) begin
            wr(4'hd, il[i], 1'b0);
            check_regs(1'b0);
        end
    endtask
    task automatic t_refused();
        logic [3:0] rs [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc};
        host.send({12'h002, 4'h1, 16'ha0ff}, 32, 1'b0);
        foreach (rs[i]) host.send({dxr_pkg::FRAME_HEADER, rs[i], 16'h0000}, 32, i < 7);
        host.send({dxr_pkg::FRAME_HEADER, 4'h1, 16'ha0ff}, 20, 1'b0);
        check_regs(1'b0);
        wr(4'h2, {8'h80, 1'b0, 7'h7f}, 1'b0);
        check_regs(1'b0);
    endtask
    task automatic t_normal();
        extended_mode_i <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            output_edge_pin_i <= i[0];
            output_swing_pin_i <= !i[0];
            repeat (8) @(posedge clock_i);
            check_regs(1'b1);
        end
        host.send({dxr_pkg::FRAME_HEADER, 4'h1, 16'ha0ff}, 32, 1'b0);
        extended_mode_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        check_regs(1'b0);
    endtask
    // counts, verdict and stop
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        rst_i = 1'b1;
        enable_i = 1'b1;
        extended_mode_i = 1'b1;
        output_edge_pin_i = 1'b0;
        output_swing_pin_i = 1'b1;
        foreach (rv[a]) rv[a] = 16'h0000;
        rv[1] = dxr_pkg::RST_CONFIG;
        rv[2] = dxr_pkg::RST_OFS;
        rv[3] = dxr_pkg::RST_GAIN;
        rv[10] = dxr_pkg::RST_OFS;
        rv[11] = dxr_pkg::RST_GAIN;
        rv[13] = dxr_pkg::RST_INTERLEAVE;
        rv[14] = dxr_pkg::RST_SKEW;
        rv[15] = 16'h007f;
        sh = rv;
        repeat (6) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        check_regs(1'b0);
        t_first_pass();
        t_config();
        t_channels();
        t_interleave();
        t_refused();
        t_normal();
        end_sim();
    end
endmodule
bind dxr_ctrl_regs dxr_ctrl_regs_assertions chk (.*);
